// File: core/e1_tx_pkg.sv
package e1_tx_pkg;
  // ----------------------------------------------------------------
  // Frame geometry
  // ----------------------------------------------------------------
  localparam int unsigned SLOTS_PER_FRAME = 32;
  localparam int unsigned FRAMES_PER_MF   = 16;
  localparam logic [4:0]  SLOT_ALIGN      = 5'h00;  // Alignment slot
  localparam logic [4:0]  SLOT_SIG        = 5'h10;  // Signalling slot
  localparam logic [4:0]  SLOT_LAST       = 5'h1f;
  localparam logic [3:0]  FRAME_LAST      = 4'hf;
  localparam logic [3:0]  FRAME_E1        = 4'hd;   // First error flag frame
  localparam logic [3:0]  FRAME_E2        = 4'hf;   // Second error flag frame
  localparam logic [3:0]  FRAME_SMF2      = 4'h8;   // Start of second half
  // ----------------------------------------------------------------
  // Patterns
  // ----------------------------------------------------------------
  localparam logic [6:0]  ALIGN_WORD      = 7'h1b;  // 0011011
  localparam logic [5:0]  MF_ALIGN        = 6'h0b;  // 001011
  localparam logic [3:0]  SIG_MF_ALIGN    = 4'h0;   // 0000
  localparam logic [7:0]  ALL_ONES        = 8'hff;
  localparam logic [3:0]  CRC_POLY        = 4'h3;   // x^4 + x + 1
endpackage

// File: core/e1_crc4.sv
`timescale 1ns/1ps
// ------------------------------------------------------------------
// Serial-byte CRC-4 over one sub-multiframe
// ------------------------------------------------------------------
module e1_crc4 (
  // Clock and reset
  input  wire logic       clock_in,
  input  wire logic       sys_rst_in,
  // Byte stream
  input  wire logic       byte_valid_in,
  input  wire logic [7:0] byte_in,
  input  wire logic       smf_start_in,   // First byte of a sub-multiframe
  // Result of the previous sub-multiframe
  output logic [3:0]      crc_out
);
  logic [3:0] rem_ff;   // Running remainder
  logic [3:0] crc_ff;   // Latched result

  // Eight bit steps, msb first
  function automatic logic [3:0] crc_step(input logic [3:0] r, input logic [7:0] d);
    logic [3:0] t;
    t = r;
    for (int i = 7; i >= 0; i--) begin
      if (t[3] ^ d[i]) begin
        t = {t[2:0], 1'b0} ^ e1_tx_pkg::CRC_POLY;
      end else begin
        t = {t[2:0], 1'b0};
      end
    end
    return t;
  endfunction

  // Remainder restarts each sub-multiframe; result moves to next one
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      rem_ff <= 4'h0;
      crc_ff <= 4'h0;
    end else if (byte_valid_in) begin
      if (smf_start_in) begin
        crc_ff <= rem_ff;
        rem_ff <= crc_step(4'h0, byte_in);
      end else begin
        rem_ff <= crc_step(rem_ff, byte_in);
      end
    end
  end

  // Bypass at the boundary, so C1 of the new half is already current
  assign crc_out = smf_start_in ? rem_ff : crc_ff;
endmodule

// File: core/e1_tx_fifo.sv
`timescale 1ns/1ps
// ------------------------------------------------------------------
// Small line-side byte FIFO with refresh
// ------------------------------------------------------------------
module e1_tx_fifo #(
  parameter int unsigned DEPTH_LOG2 = 3
) (
  // Clock and reset
  input  wire logic       clock_in,
  input  wire logic       sys_rst_in,
  input  wire logic       refresh_in,   // Empties the FIFO
  // Write side
  input  wire logic       wr_in,
  input  wire logic [7:0] wr_data_in,
  // Read side
  input  wire logic       rd_in,
  output logic [7:0]      rd_data_out,
  output logic            empty_out,
  output logic            full_out
);
  logic [7:0]            mem [2**DEPTH_LOG2];
  logic [DEPTH_LOG2:0]   wp_ff;
  logic [DEPTH_LOG2:0]   rp_ff;
  logic                  do_wr;
  logic                  do_rd;

  assign empty_out   = (wp_ff == rp_ff);
  assign full_out    = (wp_ff[DEPTH_LOG2] != rp_ff[DEPTH_LOG2]) &&
                       (wp_ff[DEPTH_LOG2-1:0] == rp_ff[DEPTH_LOG2-1:0]);
  assign do_wr       = wr_in && !full_out;
  assign do_rd       = rd_in && !empty_out;
  assign rd_data_out = mem[rp_ff[DEPTH_LOG2-1:0]];

  // Storage, no reset needed
  always_ff @(posedge clock_in) begin
    if (do_wr) begin
      mem[wp_ff[DEPTH_LOG2-1:0]] <= wr_data_in;
    end
  end

  // Pointers; refresh reinitialises like reset
  always_ff @(posedge clock_in) begin
    if (sys_rst_in || refresh_in) begin
      wp_ff <= '0;
      rp_ff <= '0;
    end else begin
      if (do_wr) begin
        wp_ff <= wp_ff + 1'b1;
      end
      if (do_rd) begin
        rp_ff <= rp_ff + 1'b1;
      end
    end
  end
endmodule

// File: core/e1_transmit_frame_generator.sv
// Contract
// - Even frames alignment word, odd bit2 one
// - CRC mode: MF pattern odd, CRC even
// - CRC per sub-multiframe, sent next one
// - Path CRC: pass or recompute CRC
// - CAS: 0000 in frame0 slot16, signalling
// - Idle code substitution, skip slot16 under CAS
// - Remote alarm in NFAS bit3
// - Manual alarm forces bit to one
// - Auto alarm variant0: four receive conditions
// - Auto alarm variant1: two receive conditions
// - Both alarm controls off gives zero
// - Frames 13/15 report received CRC errors
// - Out of sync forces error bits
// - Frame0 slot16 bit6 multiframe alarm, forceable
// - No CRC: spare bits in international bits
// - Reporting off: spare bits frames 13/15
// - Enabled national bits replace selected position
// - Extra bits into slot16 bits 5,7,8
// - Three diagnostic pattern inversions
// - All ones beats everything else
// - Slot16-only or full all ones
// - FIFO buffers output, refresh reinitialises
// - Flag end of multiframe first frame, gated irq
`timescale 1ns/1ps
module e1_transmit_frame_generator #(
  parameter int unsigned FIFO_DEPTH_LOG2 = 3
) (
  // Clock and reset
  input  wire logic       clock_in,
  input  wire logic       sys_rst_in,
  // System side payload
  input  wire logic       tx_valid_in,        // One byte per strobe
  input  wire logic [7:0] tx_system_data_in,
  input  wire logic [3:0] tx_system_signalling_in,
  input  wire logic [3:0] sig_code_in,         // Fixed ABCD code
  input  wire logic [7:0] idle_code_in,
  output logic            tx_ready_out,
  // Frame controls
  input  wire logic       frame_gen_disable_in,
  input  wire logic       crc_multiframe_gen_in,
  input  wire logic       intl_bit_insert_disable_in,
  input  wire logic       path_crc_mode_in,    // 1: keep incoming CRC
  input  wire logic       signalling_enable_in,
  input  wire logic       datalink_enable_in,
  input  wire logic       signalling_source_sel_in,
  input  wire logic       trunk_conditioning_in,
  input  wire logic       payload_ctrl_enable_in,
  input  wire logic [1:0] spare_bits_in,       // [1] FAS and frame 13, [0] NFAS and frame 15
  input  wire logic [3:0] national_bit_values_in,
  input  wire logic [3:0] national_bit_enables_in,
  input  wire logic [2:0] national_bit_position_in,
  input  wire logic       extra_bit_disable_in,
  input  wire logic [2:0] extra_bits_in,
  // Alarm controls
  input  wire logic       manual_remote_alarm_in,
  input  wire logic       auto_remote_alarm_in,
  input  wire logic       alarm_variant_sel_in,
  input  wire logic       far_error_report_disable_in,
  input  wire logic       out_of_sync_ebit_sel_in,
  input  wire logic       mf_alarm_in,
  input  wire logic       mf_alarm_force_en_in,
  input  wire logic       mf_alarm_force_val_in,
  input  wire logic       align_word_invert_in,
  input  wire logic       nfas_bit2_invert_in,
  input  wire logic       sig_mf_pattern_invert_in,
  input  wire logic       slot16_all_ones_in,
  input  wire logic       all_ones_in,
  input  wire logic       tx_fifo_refresh_in,
  // Receive-side conditions
  input  wire logic       rx_frame_loss_in,
  input  wire logic       rx_ais_in,
  input  wire logic       rx_interwork_in,
  input  wire logic       rx_offline_oof_in,
  input  wire logic       rx_crc_err_smf1_in,
  input  wire logic       rx_crc_err_smf2_in,
  input  wire logic       rx_crc_mf_oos_in,
  // Status and interrupt
  input  wire logic       crc_mf_start_clear_in,
  input  wire logic       crc_mf_start_irq_en_in,
  output logic            crc_mf_start_flag_out,
  output logic            irq_out,
  // Line side
  input  wire logic       line_rd_in,
  output logic            line_valid_out,
  output logic [7:0]      line_data_out
);
  // ----------------------------------------------------------------
  // Position counters
  // ----------------------------------------------------------------
  logic [4:0] slot_ff;      // Timeslot within frame
  logic [3:0] frame_ff;     // Frame within multiframe
  logic       take;         // Byte accepted this cycle
  logic       fifo_full;
  logic       fifo_empty;
  logic [7:0] fifo_rd_data;
  logic [7:0] out_byte;     // Byte after all insertion
  logic [3:0] crc_prev;     // Remainder of last sub-multiframe
  logic       smf_start;
  logic       flag_ff;
  logic       irq_ff;
  logic       valid_ff;
  logic [7:0] data_ff;
  logic       ready_ff;

  assign take = tx_valid_in && ready_ff;

  // Slot and frame wrap together
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      slot_ff  <= 5'h00;
      frame_ff <= 4'h0;
    end else if (take) begin
      if (slot_ff == e1_tx_pkg::SLOT_LAST) begin
        slot_ff  <= 5'h00;
        frame_ff <= frame_ff + 4'h1;
      end else begin
        slot_ff <= slot_ff + 5'h01;
      end
    end
  end

  // ----------------------------------------------------------------
  // Insertion helpers
  // ----------------------------------------------------------------
  logic cas_on;
  logic rai_bit;
  logic intl_bit;
  logic ebit_err;
  logic sa_hit;

  assign cas_on    = signalling_enable_in && datalink_enable_in;
  assign smf_start = (slot_ff == e1_tx_pkg::SLOT_ALIGN) &&
                     ((frame_ff == 4'h0) || (frame_ff == e1_tx_pkg::FRAME_SMF2));

  // Remote alarm selection
  always_comb begin
    if (manual_remote_alarm_in) begin
      rai_bit = 1'b1;
    end else if (auto_remote_alarm_in && !alarm_variant_sel_in) begin
      rai_bit = rx_frame_loss_in || rx_ais_in ||
                rx_interwork_in || rx_offline_oof_in;
    end else if (auto_remote_alarm_in) begin
      rai_bit = rx_frame_loss_in || rx_ais_in;
    end else begin
      rai_bit = 1'b0;
    end
  end

  // Error flag for frames 13 and 15
  always_comb begin
    if (rx_crc_mf_oos_in) begin
      ebit_err = out_of_sync_ebit_sel_in;
    end else if (frame_ff == e1_tx_pkg::FRAME_E1) begin
      ebit_err = !rx_crc_err_smf1_in;
    end else begin
      ebit_err = !rx_crc_err_smf2_in;
    end
  end

  // International bit content
  always_comb begin
    if (!crc_multiframe_gen_in) begin
      intl_bit = frame_ff[0] ? spare_bits_in[0] : spare_bits_in[1];
    end else if (!frame_ff[0]) begin
      // CRC bits C1..C4 in even frames of each half
      intl_bit = crc_prev[3 - frame_ff[2:1]];
    end else if (frame_ff == e1_tx_pkg::FRAME_E1 ||
                 frame_ff == e1_tx_pkg::FRAME_E2) begin
      if (far_error_report_disable_in) begin
        intl_bit = (frame_ff == e1_tx_pkg::FRAME_E1) ?
                   spare_bits_in[1] : spare_bits_in[0];
      end else begin
        intl_bit = ebit_err;
      end
    end else begin
      intl_bit = e1_tx_pkg::MF_ALIGN[5 - frame_ff[3:1]];
    end
  end

  // National bit position decode, bits 1:0 pick the bit, odd frames only
  assign sa_hit = frame_ff[0] && national_bit_enables_in[national_bit_position_in[1:0]];

  // ----------------------------------------------------------------
  // Byte builder, all ones applied last so it wins
  // ----------------------------------------------------------------
  always_comb begin
    out_byte = tx_system_data_in;
    if (slot_ff == e1_tx_pkg::SLOT_ALIGN) begin
      if (!frame_gen_disable_in) begin
        if (!frame_ff[0]) begin
          out_byte[6:0] = align_word_invert_in ? ~e1_tx_pkg::ALIGN_WORD
                                               : e1_tx_pkg::ALIGN_WORD;
        end else begin
          out_byte[6] = !nfas_bit2_invert_in;
          out_byte[5] = rai_bit;
          if (sa_hit) begin
            out_byte[3'h4 - {1'b0, national_bit_position_in[1:0]}] =
              national_bit_values_in[national_bit_position_in[1:0]];
          end
        end
      end
      if (!intl_bit_insert_disable_in &&
          !(crc_multiframe_gen_in && path_crc_mode_in && !frame_ff[0])) begin
        out_byte[7] = intl_bit;
      end
    end else if (slot_ff == e1_tx_pkg::SLOT_SIG && cas_on) begin
      if (frame_ff == 4'h0) begin
        out_byte[7:4] = sig_mf_pattern_invert_in ? ~e1_tx_pkg::SIG_MF_ALIGN
                                                 : e1_tx_pkg::SIG_MF_ALIGN;
        out_byte[2] = mf_alarm_force_en_in ? mf_alarm_force_val_in
                                           : mf_alarm_in;
        if (!extra_bit_disable_in) begin
          out_byte[3] = extra_bits_in[2];
          out_byte[1] = extra_bits_in[1];
          out_byte[0] = extra_bits_in[0];
        end
      end else begin
        out_byte[3:0] = signalling_source_sel_in ? sig_code_in
                                                 : tx_system_signalling_in;
      end
    end else if (trunk_conditioning_in && payload_ctrl_enable_in) begin
      out_byte = idle_code_in;
    end
    if (trunk_conditioning_in && payload_ctrl_enable_in && !cas_on &&
        slot_ff == e1_tx_pkg::SLOT_SIG) begin
      out_byte = idle_code_in;
    end
    if (all_ones_in || (slot16_all_ones_in && slot_ff == e1_tx_pkg::SLOT_SIG)) begin
      out_byte = e1_tx_pkg::ALL_ONES;
    end
  end

  // ----------------------------------------------------------------
  // CRC engine and FIFO
  // ----------------------------------------------------------------
  e1_crc4 u_crc (
    .clock_in      (clock_in),
    .sys_rst_in    (sys_rst_in),
    .byte_valid_in (take),
    .byte_in       (out_byte),
    .smf_start_in  (smf_start),
    .crc_out       (crc_prev)
  );

  e1_tx_fifo #(
    .DEPTH_LOG2 (FIFO_DEPTH_LOG2)
  ) u_fifo (
    .clock_in    (clock_in),
    .sys_rst_in  (sys_rst_in),
    .refresh_in  (tx_fifo_refresh_in),
    .wr_in       (take),
    .wr_data_in  (out_byte),
    .rd_in       (line_rd_in && valid_ff),
    .rd_data_out (fifo_rd_data),
    .empty_out   (fifo_empty),
    .full_out    (fifo_full)
  );

  // Ready rests a cycle after each take: half rate, but no lost byte
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      ready_ff <= 1'b0;
    end else begin
      ready_ff <= !fifo_full && !take;
    end
  end

  // Line outputs registered from FIFO head
  always_ff @(posedge clock_in) begin
    if (sys_rst_in || tx_fifo_refresh_in) begin
      valid_ff <= 1'b0;
      data_ff  <= 8'h00;
    end else begin
      valid_ff <= !fifo_empty && !(line_rd_in && valid_ff);
      data_ff  <= fifo_rd_data;
    end
  end

  // ----------------------------------------------------------------
  // Multiframe start flag, set wins over clear
  // ----------------------------------------------------------------
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      flag_ff <= 1'b0;
      irq_ff  <= 1'b0;
    end else begin
      if (take && crc_multiframe_gen_in && frame_ff == 4'h0 &&
          slot_ff == e1_tx_pkg::SLOT_LAST) begin
        flag_ff <= 1'b1;
      end else if (crc_mf_start_clear_in) begin
        flag_ff <= 1'b0;
      end
      irq_ff <= flag_ff && crc_mf_start_irq_en_in;
    end
  end

  assign tx_ready_out          = ready_ff;
  assign crc_mf_start_flag_out = flag_ff;
  assign irq_out               = irq_ff;
  assign line_valid_out        = valid_ff;
  assign line_data_out         = data_ff;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence s_last_of_frame0;
    take && crc_multiframe_gen_in && frame_ff == 4'h0 && slot_ff == e1_tx_pkg::SLOT_LAST;
  endsequence

  chk_mf_flag_set: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    s_last_of_frame0 |=> flag_ff) else $error("flag not set");
  chk_irq_gate: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    !crc_mf_start_irq_en_in |=> !irq_ff) else $error("irq not masked");
  chk_all_ones: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    all_ones_in |-> out_byte == e1_tx_pkg::ALL_ONES) else $error("all ones lost");
  chk_slot16_ones: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    slot16_all_ones_in && slot_ff == e1_tx_pkg::SLOT_SIG |-> out_byte == 8'hff)
    else $error("slot16 not ones");
  chk_align_word: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    slot_ff == 5'h00 && !frame_ff[0] && !frame_gen_disable_in && !all_ones_in &&
    !align_word_invert_in |-> out_byte[6:0] == 7'h1b) else $error("bad align word");
  chk_manual_rai: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    manual_remote_alarm_in |-> rai_bit) else $error("rai not forced");
  chk_rai_off: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    !manual_remote_alarm_in && !auto_remote_alarm_in |-> !rai_bit) else $error("rai on");
  chk_slot_wrap: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    take && slot_ff == 5'h1f |=> slot_ff == 5'h00 && frame_ff == $past(frame_ff) + 4'h1)
    else $error("bad wrap");
endmodule

// File: sim/e1_line_sink.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Line side sink model
// ----------------------------------------------------------------
module e1_line_sink (
  // Clock and reset
  input  wire logic       clock_in,
  input  wire logic       sys_rst_in,
  // Line side
  input  wire logic       line_valid_in,
  input  wire logic [7:0] line_data_in,
  input  wire logic       stall_in,      // Holds reads off, a slow line
  output logic            line_rd_out
);
  logic [7:0] got [0:1023];  // Bytes in stream order
  int         count;         // Bytes taken since reset
  initial line_rd_out = 1'b0;
  // Read held to the next edge, byte taken there, then released;
  // never two reads back to back, so the line is never faster
  // than the block allows
  always @(posedge clock_in) begin
    if (sys_rst_in) begin
      count = 0;
    end else if (line_rd_out && line_valid_in) begin
      got[count[9:0]] = line_data_in;
      count = count + 1;
    end
    line_rd_out <= #1 line_valid_in && !line_rd_out && !stall_in && !sys_rst_in;
  end
endmodule

// File: sim/e1_transmit_frame_generator_bench.sv
`timescale 1ns/1ps
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin miscompares++; \
  $display("unexpected at %0t: got %h want %h", $time, g, e); end end
module e1_transmit_frame_generator_bench;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic clock_in, sys_rst_in, tx_valid_in, tx_ready_out, stall;
  logic [7:0] tx_system_data_in, idle_code_in, line_data_out, b;
  logic [3:0] tx_system_signalling_in, sig_code_in, national_bit_values_in;
  logic [3:0] national_bit_enables_in;
  logic [2:0] national_bit_position_in, extra_bits_in;
  logic [1:0] spare_bits_in, e;
  logic frame_gen_disable_in, crc_multiframe_gen_in, intl_bit_insert_disable_in;
  logic path_crc_mode_in, signalling_enable_in, datalink_enable_in;
  logic signalling_source_sel_in, trunk_conditioning_in, payload_ctrl_enable_in;
  logic extra_bit_disable_in, manual_remote_alarm_in, auto_remote_alarm_in;
  logic alarm_variant_sel_in, far_error_report_disable_in, out_of_sync_ebit_sel_in;
  logic mf_alarm_in, mf_alarm_force_en_in, mf_alarm_force_val_in, align_word_invert_in;
  logic nfas_bit2_invert_in, sig_mf_pattern_invert_in, slot16_all_ones_in, all_ones_in;
  logic tx_fifo_refresh_in, rx_frame_loss_in, rx_ais_in, rx_interwork_in;
  logic rx_offline_oof_in, rx_crc_err_smf1_in, rx_crc_err_smf2_in, rx_crc_mf_oos_in;
  logic crc_mf_start_clear_in, crc_mf_start_irq_en_in, crc_mf_start_flag_out, irq_out;
  logic line_rd_in, line_valid_out;
  int   miscompares, checks, cycles;
  localparam logic [5:0] MF_PAT = 6'h0b;  // Multiframe word, frame 1 first
  // ----------------------------------------------------------------
  // Block and line model
  // ----------------------------------------------------------------
  e1_transmit_frame_generator #(.FIFO_DEPTH_LOG2(3)) uut (
    .clock_in, .sys_rst_in, .tx_valid_in, .tx_system_data_in, .tx_system_signalling_in,
    .sig_code_in, .idle_code_in, .tx_ready_out, .frame_gen_disable_in,
    .crc_multiframe_gen_in, .intl_bit_insert_disable_in, .path_crc_mode_in,
    .signalling_enable_in, .datalink_enable_in, .signalling_source_sel_in,
    .trunk_conditioning_in, .payload_ctrl_enable_in, .spare_bits_in,
    .national_bit_values_in, .national_bit_enables_in, .national_bit_position_in,
    .extra_bit_disable_in, .extra_bits_in, .manual_remote_alarm_in, .auto_remote_alarm_in,
    .alarm_variant_sel_in, .far_error_report_disable_in, .out_of_sync_ebit_sel_in,
    .mf_alarm_in, .mf_alarm_force_en_in, .mf_alarm_force_val_in, .align_word_invert_in,
    .nfas_bit2_invert_in, .sig_mf_pattern_invert_in, .slot16_all_ones_in, .all_ones_in,
    .tx_fifo_refresh_in, .rx_frame_loss_in, .rx_ais_in, .rx_interwork_in,
    .rx_offline_oof_in, .rx_crc_err_smf1_in, .rx_crc_err_smf2_in, .rx_crc_mf_oos_in,
    .crc_mf_start_clear_in, .crc_mf_start_irq_en_in, .crc_mf_start_flag_out, .irq_out,
    .line_rd_in, .line_valid_out, .line_data_out);
  e1_line_sink sink (.clock_in, .sys_rst_in, .line_valid_in(line_valid_out),
    .line_data_in(line_data_out), .stall_in(stall), .line_rd_out(line_rd_in));
  // ----------------------------------------------------------------
  // Clock, hang guard and verdict
  // ----------------------------------------------------------------
  initial begin
    clock_in = 1'b0;
    forever #4 clock_in = ~clock_in;
  end
  // Whole run needs under 12k cycles; 20000 cycles means a hang
  always @(posedge clock_in) begin
    cycles++;
    if (cycles >= 20000) begin
      miscompares++;
      close_out();
    end
  end
  task automatic close_out();
    if (miscompares == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Payload byte k of the stream
  function automatic logic [7:0] pay(input int k);
    return k[7:0] ^ 8'h5a;
  endfunction
  // Byte sent in slot s of frame f
  function automatic logic [7:0] ob(input int f, input int s);
    return sink.got[f*32+s];
  endfunction
  function automatic logic ob1(input int f, input int s, input int i);
    return sink.got[f*32+s][i];
  endfunction
  // Quiet setup: basic framing only, spares 1 and 0
  task automatic defaults();
    {frame_gen_disable_in, crc_multiframe_gen_in, intl_bit_insert_disable_in,
     path_crc_mode_in, signalling_enable_in, datalink_enable_in, signalling_source_sel_in,
     trunk_conditioning_in, payload_ctrl_enable_in, national_bit_values_in,
     national_bit_enables_in, national_bit_position_in, extra_bits_in,
     manual_remote_alarm_in, auto_remote_alarm_in, alarm_variant_sel_in,
     far_error_report_disable_in, out_of_sync_ebit_sel_in, mf_alarm_in,
     mf_alarm_force_en_in, mf_alarm_force_val_in, align_word_invert_in, nfas_bit2_invert_in,
     sig_mf_pattern_invert_in, slot16_all_ones_in, all_ones_in, tx_fifo_refresh_in,
     rx_frame_loss_in, rx_ais_in, rx_interwork_in, rx_offline_oof_in, rx_crc_err_smf1_in,
     rx_crc_err_smf2_in, rx_crc_mf_oos_in, crc_mf_start_clear_in,
     crc_mf_start_irq_en_in} = '0;
    spare_bits_in = 2'h2;
    extra_bit_disable_in = 1'b1;
    idle_code_in = 8'h3c;
    sig_code_in = 4'ha;
    tx_system_signalling_in = 4'h5;
  endtask
  // Reset 5 cycles, stream n bytes from slot 0 frame 0, collect them
  task automatic run(input int n);
    sys_rst_in = 1'b1;
    repeat (5) @(posedge clock_in);
    #1 sys_rst_in = 1'b0;
    for (int k = 0; k < n; k++) begin
      tx_valid_in = 1'b1;
      tx_system_data_in = pay(k);
      @(posedge clock_in);
      while (tx_ready_out !== 1'b1) @(posedge clock_in);
      #1;
    end
    tx_valid_in = 1'b0;
    for (int t = 0; t < 100 && sink.count < n; t++) @(posedge clock_in);
    #1;
    `CHK(sink.count, n)
  endtask
  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    defaults();
    {tx_valid_in, tx_system_data_in, stall, sys_rst_in} = 11'h001;
    // Basic frame, spares, clear alarm bit, one national bit
    national_bit_position_in = 3'h1;
    national_bit_enables_in = 4'h2;
    run(64);
    `CHK(ob(0, 0), 8'h9b)
    b = ob(1, 0);
    `CHK(b[7:5], 3'b010)
    `CHK(b[4:3], 2'b10)
    `CHK(ob(1, 31), pay(63))
    `CHK(crc_mf_start_flag_out, 1'b0)
    // Diagnostic inversions
    defaults();
    align_word_invert_in = 1'b1;
    nfas_bit2_invert_in = 1'b1;
    run(64);
    b = ob(0, 0);
    `CHK(b[6:0], 7'h64)
    `CHK(ob1(1, 0, 6), 1'b0)
    // Framing off: payload passes in slot 0
    defaults();
    frame_gen_disable_in = 1'b1;
    intl_bit_insert_disable_in = 1'b1;
    run(64);
    `CHK(ob(0, 0), pay(0))
    `CHK(ob(1, 0), pay(32))
    // Automatic alarm, each receive condition under both variants
    defaults();
    auto_remote_alarm_in = 1'b1;
    for (int i = 0; i < 8; i++) begin
      {rx_frame_loss_in, rx_ais_in, rx_interwork_in, rx_offline_oof_in} = 4'h8 >> i[1:0];
      alarm_variant_sel_in = i[2];
      run(64);
      `CHK(ob1(1, 0, 5), !i[2] || !i[1])
    end
    // CRC multiframe with error reports, manual alarm, flag and irq
    defaults();
    crc_multiframe_gen_in = 1'b1;
    manual_remote_alarm_in = 1'b1;
    crc_mf_start_irq_en_in = 1'b1;
    for (int i = 1; i < 3; i++) begin
      {rx_crc_err_smf1_in, rx_crc_err_smf2_in} = i[1:0];
      run(512);
      for (int j = 0; j < 6; j++) `CHK(ob1(2*j+1, 0, 7), MF_PAT[5-j])
      `CHK(ob1(13, 0, 7), !i[1])
      `CHK(ob1(15, 0, 7), !i[0])
      `CHK(ob1(1, 0, 5), 1'b1)
      `CHK({crc_mf_start_flag_out, irq_out}, 2'b11)
      crc_mf_start_clear_in = 1'b1;
      @(posedge clock_in);
      #1 crc_mf_start_clear_in = 1'b0;
      repeat (2) @(posedge clock_in);
      #1;
      `CHK({crc_mf_start_flag_out, irq_out}, 2'b00)
    end
    // Reporting off: spares in frames 13, 15; kept incoming CRC bits
    defaults();
    crc_multiframe_gen_in = 1'b1;
    far_error_report_disable_in = 1'b1;
    spare_bits_in = 2'h1;
    path_crc_mode_in = 1'b1;
    rx_crc_err_smf1_in = 1'b1;
    run(512);
    `CHK({ob1(13, 0, 7), ob1(15, 0, 7)}, 2'b01)
    `CHK(ob1(4, 0, 7), 1'b1)
    `CHK({crc_mf_start_flag_out, irq_out}, 2'b10)
    // Out of multiframe sync: both error bits forced, two levels
    for (int i = 0; i < 2; i++) begin
      defaults();
      crc_multiframe_gen_in = 1'b1;
      rx_crc_mf_oos_in = 1'b1;
      rx_crc_err_smf1_in = 1'b1;
      out_of_sync_ebit_sel_in = i[0];
      run(512);
      e[i] = ob1(13, 0, 7);
      `CHK({e[i], ob1(15, 0, 7)}, {2{i[0]}})
    end
    `CHK(e[0], !e[1])
    // Signalling multiframe with idle trunk code
    defaults();
    {signalling_enable_in, datalink_enable_in, mf_alarm_in} = 3'h7;
    {trunk_conditioning_in, payload_ctrl_enable_in} = 2'h3;
    run(64);
    b = ob(0, 16);
    `CHK({b[7:4], b[2]}, 5'h01)
    `CHK(ob(0, 5), 8'h3c)
    `CHK(ob(0, 0), 8'h9b)
    `CHK(ob(1, 16), 8'h65)
    sig_mf_pattern_invert_in = 1'b1;
    {mf_alarm_force_en_in, signalling_source_sel_in, extra_bit_disable_in} = 3'h6;
    extra_bits_in = 3'h7;
    run(64);
    b = ob(0, 16);
    `CHK({b[7:4], b[2]}, 5'h1e)
    `CHK({b[3], b[1:0]}, 3'h7)
    // Idle code on slot 16 without signalling, then slot 16 all ones
    defaults();
    {trunk_conditioning_in, payload_ctrl_enable_in} = 2'h3;
    run(64);
    `CHK(ob(1, 16), 8'h3c)
    slot16_all_ones_in = 1'b1;
    run(64);
    `CHK(ob(0, 16), 8'hff)
    `CHK(ob(0, 5), 8'h3c)
    all_ones_in = 1'b1;
    align_word_invert_in = 1'b1;
    run(64);
    `CHK({ob(0, 0), ob(1, 0), ob(0, 5)}, 24'hffffff)
    // Line stalled: fill until refused, then refresh empties
    defaults();
    stall = 1'b1;
    sys_rst_in = 1'b1;
    repeat (5) @(posedge clock_in);
    #1 sys_rst_in = 1'b0;
    tx_valid_in = 1'b1;
    repeat (20) @(posedge clock_in);
    #1 tx_valid_in = 1'b0;
    `CHK({tx_ready_out, line_valid_out}, 2'b01)
    tx_fifo_refresh_in = 1'b1;
    @(posedge clock_in);
    #1 tx_fifo_refresh_in = 1'b0;
    repeat (2) @(posedge clock_in);
    #1;
    `CHK({tx_ready_out, line_valid_out}, 2'b10)
    close_out();
  end
endmodule
